// >>> rtl/addr_core_pkg.sv
// Constants for the program counter, return stack and indirect addressing.
// Assumes a single 125 MHz instruction clock and an APB register slave.

package addr_core_pkg;

   // Widths
   localparam int PC_W        = 13;
   localparam int LOW_W       = 8;
   localparam int UP_W        = 5;
   localparam int TGT_W       = 11;
   localparam int PTR_W       = 8;
   localparam int EA_W        = 9;
   localparam int DIRECT_W    = 7;
   localparam int STK_DEPTH   = 8;
   localparam int APB_AW      = 12;
   localparam int APB_DW      = 32;

   // Latch field positions
   localparam int LATCH_HI    = 4;
   localparam int LATCH_JMP_LO = 3;

   // Register byte offsets
   localparam logic [11:0] OFF_PC_LOW   = 12'h000;
   localparam logic [11:0] OFF_UP_LATCH = 12'h004;
   localparam logic [11:0] OFF_POINTER  = 12'h008;
   localparam logic [11:0] OFF_BANK     = 12'h00C;

   // Reset values
   localparam logic [PC_W-1:0]  PC_RST     = 13'h0000;
   localparam logic [UP_W-1:0]  LATCH_RST  = 5'h00;
   localparam logic [PTR_W-1:0] POINTER_RST = 8'h00;
   localparam logic             BANK_RST   = 1'b0;

   // Direct address of the indirect data port within a bank
   localparam logic [DIRECT_W-1:0] INDIRECT_PORT_ADDR = 7'h00;

   // Register bus slave states
   typedef enum logic [1:0] {
      APB_IDLE = 2'b01,
      APB_ACK  = 2'b10
   } apb_state_t;

endpackage

// >>> rtl/pc_stack.sv
// Circular return-address stack with a hidden pointer.
// Assumes push and pop never come in the same cycle.

`timescale 1ns/1ns

module pc_stack #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst,
   // Stack control
   input  wire logic             push,
   input  wire logic             pop,
   input  wire logic [WIDTH-1:0] push_data,
   output logic      [WIDTH-1:0] top_data
);

   localparam int PW = $clog2(DEPTH);
   localparam logic [PW-1:0] PTR_ONE = PW'(1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr_ff;
   logic [PW-1:0]    nxt_wr_ptr;
   logic [PW-1:0]    top_idx;

   // Pointer wraps by width alone, so DEPTH must be a power of two
   assign top_idx    = wr_ptr_ff - PTR_ONE;
   assign top_data   = mem[top_idx];
   assign nxt_wr_ptr = push ? wr_ptr_ff + PTR_ONE :
                       pop  ? top_idx : wr_ptr_ff;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wr_ptr_ff <= '0;
      end else begin
         wr_ptr_ff <= nxt_wr_ptr;
      end
   end

   // Oldest entry silently overwritten once full
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr_ff] <= push_data;
      end
   end

endmodule // pc_stack

// >>> rtl/program_counter_stack_indirect.sv
// Program counter, return stack and indirect address former of the core.
// Assumes the execution unit drives one-cycle strobes on ref_clk and an
// APB master reaches the low byte, latch, pointer and bank registers.
// Limitation: stack words survive reset; only the stack pointer clears.

`timescale 1ns/1ns

module program_counter_stack_indirect #(
   parameter int STACK_DEPTH = addr_core_pkg::STK_DEPTH
) (
   // Clock and reset
   input  wire logic                             ref_clk,
   input  wire logic                             rst,

   // APB slave
   input  wire logic                             psel,
   input  wire logic                             penable,
   input  wire logic                             pwrite,
   input  wire logic [addr_core_pkg::APB_AW-1:0] paddr,
   input  wire logic [addr_core_pkg::APB_DW-1:0] pwdata,
   output logic      [addr_core_pkg::APB_DW-1:0] prdata,
   output logic                                  pready,
   output logic                                  pslverr,

   // Sequencing from the execution unit
   input  wire logic                             pc_advance,
   input  wire logic                             goto_req,
   input  wire logic                             call_req,
   input  wire logic [addr_core_pkg::TGT_W-1:0]  instr_target,
   input  wire logic                             vector_req,
   input  wire logic [addr_core_pkg::PC_W-1:0]   vector_addr,
   input  wire logic                             return_req,
   input  wire logic                             return_with_literal_instr,
   input  wire logic                             return_from_interrupt_instr,

   // Special register writes from the execution unit
   input  wire logic                             core_pcl_wr,
   input  wire logic                             core_latch_wr,
   input  wire logic                             core_pointer_wr,
   input  wire logic                             core_bank_wr,
   input  wire logic [addr_core_pkg::LOW_W-1:0]  core_wdata,

   // Data access request
   input  wire logic                             acc_valid,
   input  wire logic                             acc_write,
   input  wire logic [addr_core_pkg::EA_W-1:0]   acc_addr,

   // Program counter out
   output logic      [addr_core_pkg::PC_W-1:0]   pc,

   // Data access out
   output logic                                  mem_valid,
   output logic                                  mem_write,
   output logic      [addr_core_pkg::EA_W-1:0]   mem_addr,
   output logic                                  mem_read_zero
);

   localparam int PC_W  = addr_core_pkg::PC_W;
   localparam int LOW_W = addr_core_pkg::LOW_W;
   localparam int UP_W  = addr_core_pkg::UP_W;
   localparam int EA_W  = addr_core_pkg::EA_W;
   localparam int HI    = addr_core_pkg::LATCH_HI;
   localparam int JLO   = addr_core_pkg::LATCH_JMP_LO;
   localparam logic [PC_W-1:0] PC_ONE = 13'h0001;

   // State
   logic [PC_W-1:0]                 pc_ff;
   logic [UP_W-1:0]                 pc_upper_latch_ff;
   logic [addr_core_pkg::PTR_W-1:0] indirect_pointer_reg_ff;
   logic                            indirect_bank_bit_ff;
   addr_core_pkg::apb_state_t       apb_state_ff;
   logic [addr_core_pkg::APB_DW-1:0] prdata_ff;
   logic                            pready_ff;
   logic                            pslverr_ff;
   logic                            mem_valid_ff;
   logic                            mem_write_ff;
   logic [EA_W-1:0]                 mem_addr_ff;
   logic                            mem_read_zero_ff;

   // Next values
   logic [PC_W-1:0]                 nxt_pc;
   logic [UP_W-1:0]                 nxt_latch;
   logic [addr_core_pkg::PTR_W-1:0] nxt_pointer;
   logic                            nxt_bank;
   addr_core_pkg::apb_state_t       nxt_apb_state;

   // Next values of the output flops
   logic [addr_core_pkg::APB_DW-1:0] nxt_prdata;
   logic                            nxt_pready;
   logic                            nxt_pslverr;
   logic                            nxt_mem_valid;
   logic                            nxt_mem_write;
   logic [EA_W-1:0]                 nxt_mem_addr;
   logic                            nxt_mem_read_zero;

   // Register decode
   wire apb_access  = psel & penable;
   wire hit_pc_low  = paddr == addr_core_pkg::OFF_PC_LOW;
   wire hit_latch   = paddr == addr_core_pkg::OFF_UP_LATCH;
   wire hit_pointer = paddr == addr_core_pkg::OFF_POINTER;
   wire hit_bank    = paddr == addr_core_pkg::OFF_BANK;
   // Stack pointer has no address of its own
   wire apb_hit     = hit_pc_low | hit_latch | hit_pointer | hit_bank;
   wire apb_commit  = apb_access & (apb_state_ff == addr_core_pkg::APB_ACK);
   wire apb_wr      = apb_commit & pwrite;

   // Core strobes take the cycle; a colliding bus write is dropped
   wire apb_pcl_wr     = apb_wr & hit_pc_low & ~core_pcl_wr;
   wire apb_latch_wr   = apb_wr & hit_latch & ~core_latch_wr;
   wire apb_pointer_wr = apb_wr & hit_pointer & ~core_pointer_wr;
   wire apb_bank_wr    = apb_wr & hit_bank & ~core_bank_wr;

   // Read mux; upper counter bits are never visible here
   wire [LOW_W-1:0] pc_low_byte_reg = pc_ff[LOW_W-1:0];
   wire [addr_core_pkg::APB_DW-1:0] rd_pc_low =
      {{(addr_core_pkg::APB_DW-LOW_W){1'b0}}, pc_low_byte_reg};
   wire [addr_core_pkg::APB_DW-1:0] rd_latch =
      {{(addr_core_pkg::APB_DW-UP_W){1'b0}}, pc_upper_latch_ff};
   wire [addr_core_pkg::APB_DW-1:0] rd_pointer =
      {{(addr_core_pkg::APB_DW-LOW_W){1'b0}}, indirect_pointer_reg_ff};
   wire [addr_core_pkg::APB_DW-1:0] rd_bank =
      {{(addr_core_pkg::APB_DW-1){1'b0}}, indirect_bank_bit_ff};
   wire [addr_core_pkg::APB_DW-1:0] apb_rdata =
      hit_pc_low  ? rd_pc_low :
      hit_latch   ? rd_latch :
      hit_pointer ? rd_pointer :
      hit_bank    ? rd_bank : '0;

   // Program counter sources
   wire return_any = return_req | return_with_literal_instr |
                     return_from_interrupt_instr;
   wire [PC_W-1:0] pc_inc = pc_ff + PC_ONE;
   wire [PC_W-1:0] jump_target =
      {pc_upper_latch_ff[HI:JLO], instr_target};
   wire [PC_W-1:0] pcl_load_core =
      {pc_upper_latch_ff, core_wdata};
   wire [PC_W-1:0] pcl_load_apb =
      {pc_upper_latch_ff, pwdata[LOW_W-1:0]};
   wire [PC_W-1:0] stack_top;

   // Stack control; the return address of a call is the next word
   wire stack_pop  = return_any;
   wire stack_push = ~return_any & (vector_req | call_req);
   wire [PC_W-1:0] push_value = vector_req ? pc_ff : pc_inc;

   // Returns first, then vectoring, call, goto, low-byte writes, advance
   assign nxt_pc = return_any  ? stack_top :
                   vector_req  ? vector_addr :
                   call_req    ? jump_target :
                   goto_req    ? jump_target :
                   core_pcl_wr ? pcl_load_core :
                   apb_pcl_wr  ? pcl_load_apb :
                   pc_advance  ? pc_inc : pc_ff;

   // Latch changes only on explicit writes, never on push or pop
   assign nxt_latch = core_latch_wr ? core_wdata[UP_W-1:0] :
                      apb_latch_wr  ? pwdata[UP_W-1:0] :
                      pc_upper_latch_ff;

   // Core write beats a bus write landing in the same cycle
   assign nxt_pointer = core_pointer_wr ? core_wdata :
                        apb_pointer_wr  ? pwdata[LOW_W-1:0] :
                        indirect_pointer_reg_ff;

   // Bank bit tops the indirect address
   assign nxt_bank = core_bank_wr ? core_wdata[0] :
                     apb_bank_wr  ? pwdata[0] :
                     indirect_bank_bit_ff;

   // Indirect addressing
   wire acc_to_port = acc_addr[addr_core_pkg::DIRECT_W-1:0] ==
                      addr_core_pkg::INDIRECT_PORT_ADDR;
   wire [EA_W-1:0] indirect_ea =
      {indirect_bank_bit_ff, indirect_pointer_reg_ff};
   wire ea_is_port = indirect_ea[addr_core_pkg::DIRECT_W-1:0] ==
                     addr_core_pkg::INDIRECT_PORT_ADDR;
   wire self_access = acc_valid & acc_to_port & ea_is_port;
   wire [EA_W-1:0] eff_addr = acc_to_port ? indirect_ea : acc_addr;
   // Status flags stay with the execution unit, which still sees the access
   wire eff_write = acc_valid & acc_write & ~self_access;
   wire eff_zero  = self_access & ~acc_write;

   // Bus slave: one wait state, then the answer
   always_comb begin
      nxt_apb_state = apb_state_ff;
      unique case (apb_state_ff)
         addr_core_pkg::APB_IDLE: begin
            if (apb_access) begin
               nxt_apb_state = addr_core_pkg::APB_ACK;
            end
         end
         addr_core_pkg::APB_ACK: begin
            nxt_apb_state = addr_core_pkg::APB_IDLE;
         end
      endcase
   end

   // Idle with an access opens the one wait-state answer
   wire start_ack = apb_access & (apb_state_ff == addr_core_pkg::APB_IDLE);

   // Read data is zero outside the answer cycle
   assign nxt_pready  = start_ack;
   assign nxt_prdata  = (start_ack & ~pwrite) ? apb_rdata : 32'h0000_0000;
   assign nxt_pslverr = start_ack & ~apb_hit;

   // Data access stage, one cycle behind the request
   assign nxt_mem_valid     = acc_valid;
   assign nxt_mem_write     = eff_write;
   assign nxt_mem_addr      = eff_addr;
   assign nxt_mem_read_zero = eff_zero;

   // Bus slave state
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         apb_state_ff <= addr_core_pkg::APB_IDLE;
      end else begin
         apb_state_ff <= nxt_apb_state;
      end
   end

   // Ready is a one-cycle pulse per transfer
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= nxt_pready;
      end
   end

   // Read data register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prdata_ff <= 32'h0000_0000;
      end else begin
         prdata_ff <= nxt_prdata;
      end
   end

   // Error flag, only for an unmapped address
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pslverr_ff <= 1'b0;
      end else begin
         pslverr_ff <= nxt_pslverr;
      end
   end

   // Counter, cleared by every kind of reset
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pc_ff <= addr_core_pkg::PC_RST;
      end else begin
         pc_ff <= nxt_pc;
      end
   end

   // Upper latch, untouched by stack traffic
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pc_upper_latch_ff <= addr_core_pkg::LATCH_RST;
      end else begin
         pc_upper_latch_ff <= nxt_latch;
      end
   end

   // Pointer register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         indirect_pointer_reg_ff <= addr_core_pkg::POINTER_RST;
      end else begin
         indirect_pointer_reg_ff <= nxt_pointer;
      end
   end

   // Bank bit
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         indirect_bank_bit_ff <= addr_core_pkg::BANK_RST;
      end else begin
         indirect_bank_bit_ff <= nxt_bank;
      end
   end

   // Access valid
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mem_valid_ff <= 1'b0;
      end else begin
         mem_valid_ff <= nxt_mem_valid;
      end
   end

   // Effective write enable
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mem_write_ff <= 1'b0;
      end else begin
         mem_write_ff <= nxt_mem_write;
      end
   end

   // Effective address
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mem_addr_ff <= 9'h000;
      end else begin
         mem_addr_ff <= nxt_mem_addr;
      end
   end

   // Zero-data flag for a self read
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mem_read_zero_ff <= 1'b0;
      end else begin
         mem_read_zero_ff <= nxt_mem_read_zero;
      end
   end

   // Return stack, separate from program and data memory
   pc_stack #(
      .WIDTH (PC_W),
      .DEPTH (STACK_DEPTH)
   ) u_stack (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .push      (stack_push),
      .pop       (stack_pop),
      .push_data (push_value),
      .top_data  (stack_top)
   );

   // Outputs
   assign prdata        = prdata_ff;
   assign pready        = pready_ff;
   assign pslverr       = pslverr_ff;
   assign pc            = pc_ff;
   assign mem_valid     = mem_valid_ff;
   assign mem_write     = mem_write_ff;
   assign mem_addr      = mem_addr_ff;
   assign mem_read_zero = mem_read_zero_ff;

endmodule // program_counter_stack_indirect

// >>> tb/core_seq_model.sv
// Stand-in for the execution unit: one command code, one strobe.
// Assumes the bench changes cmd just after a rising edge.
`timescale 1ns/1ns
module core_seq_model (
   // Command from the bench
   input  wire logic [3:0] cmd,
   // Strobes to the addressing block
   output logic            pc_advance,
   output logic            goto_req,
   output logic            call_req,
   output logic            vector_req,
   output logic            return_req,
   output logic            return_with_literal_instr,
   output logic            return_from_interrupt_instr,
   output logic            core_pcl_wr,
   output logic            core_latch_wr,
   output logic            core_pointer_wr,
   output logic            core_bank_wr
);
   // One strobe at a time, so priority never hides a step
   assign pc_advance                  = cmd == 4'h1;
   assign goto_req                    = cmd == 4'h2;
   assign call_req                    = cmd == 4'h3;
   assign vector_req                  = cmd == 4'h4;
   assign return_req                  = cmd == 4'h5;
   assign return_with_literal_instr   = cmd == 4'h6;
   assign return_from_interrupt_instr = cmd == 4'h7;
   assign core_pcl_wr                 = cmd == 4'h8;
   assign core_latch_wr               = cmd == 4'h9;
   assign core_pointer_wr             = cmd == 4'hA;
   assign core_bank_wr                = cmd == 4'hB;
endmodule // core_seq_model

// >>> tb/addr_core_chk.sv
// Checker on the top ports of the addressing block.
// Assumes the bind below; everything samples on ref_clk.
`timescale 1ns/1ns
module addr_core_chk #(
   parameter int STACK_DEPTH = 8
) (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        rst,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Sequencing
   input wire logic        goto_req,
   input wire logic        call_req,
   input wire logic [10:0] instr_target,
   input wire logic        vector_req,
   input wire logic [12:0] vector_addr,
   input wire logic        return_req,
   input wire logic        return_with_literal_instr,
   input wire logic        return_from_interrupt_instr,
   input wire logic        core_pcl_wr,
   input wire logic [7:0]  core_wdata,
   // Data access and counter
   input wire logic        acc_valid,
   input wire logic        acc_write,
   input wire logic [8:0]  acc_addr,
   input wire logic [12:0] pc,
   input wire logic        mem_valid,
   input wire logic        mem_write,
   input wire logic [8:0]  mem_addr,
   input wire logic        mem_read_zero
);
   wire ret_any = return_req | return_with_literal_instr
                | return_from_interrupt_instr;
   wire above   = ret_any | vector_req | call_req | goto_req;
   wire mapped  = paddr inside {12'h000, 12'h004, 12'h008, 12'h00C};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   pc_reset_a: assert property (disable iff (1'b0)
      rst |=> pc == 13'h0000) else $error("pc not cleared");
   goto_load_a: assert property (goto_req && !ret_any && !vector_req
      && !call_req |=> pc[10:0] == $past(instr_target))
      else $error("goto target lost");
   call_load_a: assert property (call_req && !ret_any && !vector_req
      |=> pc[10:0] == $past(instr_target)) else $error("call target lost");
   vector_load_a: assert property (vector_req && !ret_any
      |=> pc == $past(vector_addr)) else $error("vector not taken");
   pcl_load_a: assert property (core_pcl_wr && !above
      |=> pc[7:0] == $past(core_wdata)) else $error("low byte lost");
   apb_answer_a: assert property (psel && penable && !pready
      |=> pready ##1 !pready) else $error("bad apb answer");
   unmapped_err_a: assert property (psel && penable && !pready
      && !mapped |=> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access accepted");
   direct_pass_a: assert property (acc_valid
      && acc_addr[6:0] != 7'h00 |=> mem_valid && mem_addr == $past(acc_addr)
      && mem_write == $past(acc_write)) else $error("direct access bad");
   self_write_a: assert property (mem_valid
      && mem_addr[6:0] == 7'h00 |-> !mem_write) else $error("self write");
   self_read_a: assert property (acc_valid && !acc_write
      |=> mem_read_zero == (mem_addr[6:0] == 7'h00))
      else $error("read zero flag bad");
   cover property (call_req ##1 return_req);
   cover property (mem_read_zero);
   cover property (pslverr);
endmodule // addr_core_chk

bind program_counter_stack_indirect addr_core_chk #(
   .STACK_DEPTH(STACK_DEPTH)
) addr_core_chk_i (
   .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .goto_req(goto_req), .call_req(call_req), .instr_target(instr_target),
   .vector_req(vector_req), .vector_addr(vector_addr),
   .return_req(return_req),
   .return_with_literal_instr(return_with_literal_instr),
   .return_from_interrupt_instr(return_from_interrupt_instr),
   .core_pcl_wr(core_pcl_wr), .core_wdata(core_wdata),
   .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr),
   .pc(pc), .mem_valid(mem_valid), .mem_write(mem_write),
   .mem_addr(mem_addr), .mem_read_zero(mem_read_zero)
);

// >>> tb/program_counter_stack_indirect_tb_top.sv
// Random and corner bench for the counter, stack and indirect block.
// Assumes the core stand-in and the checker bind are compiled first.
`timescale 1ns/1ns
module program_counter_stack_indirect_tb_top;
   logic        ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic        pready, pslverr, err, acc_valid = 0, acc_write = 0;
   logic        pc_advance, goto_req, call_req, vector_req, return_req;
   logic        return_with_literal_instr, return_from_interrupt_instr;
   logic        core_pcl_wr, core_latch_wr, core_pointer_wr, core_bank_wr;
   logic        mem_valid, mem_write, mem_read_zero, m_bank = 0;
   logic [3:0]  cmd = 0;
   logic [4:0]  m_lat = 0;
   logic [7:0]  core_wdata = 0, m_ptr = 0;
   logic [8:0]  acc_addr = 0, mem_addr;
   logic [10:0] instr_target = 0;
   logic [11:0] paddr = 0;
   logic [12:0] vector_addr = 0, pc, m_pc = 0, r;
   logic [12:0] m_stk [8];
   logic [31:0] pwdata = 0, prdata, rd, seed = 32'h0001_271A;
   int          sp = 0, fails = 0, total_checks = 0;
   core_seq_model core_seq_model_i (.*);
   program_counter_stack_indirect program_counter_stack_indirect_i (.*);
   always #4 ref_clk = ~ref_clk;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic close_out();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_pc(input logic [12:0] got, input logic [12:0] exp);
      chk_val({19'h0_0000, got}, {19'h0_0000, exp});
   endtask
   // Counter is settled mid-cycle, long after the edge that moved it
   always @(negedge ref_clk) if (!rst) chk_pc(pc, m_pc);
   task automatic op(input logic [3:0] c, input logic [12:0] d);
      cmd <= c;
      instr_target <= d[10:0];
      vector_addr <= d;
      core_wdata <= d[7:0];
      @(posedge ref_clk);
      case (c)
         4'h1: m_pc = m_pc + 13'h0001;
         4'h2: m_pc = {m_lat[4:3], d[10:0]};
         4'h3, 4'h4: begin
            m_stk[sp] = (c == 4'h3) ? m_pc + 13'h0001 : m_pc;
            sp = (sp + 1) % 8;
            m_pc = (c == 4'h3) ? {m_lat[4:3], d[10:0]} : d;
         end
         4'h5, 4'h6, 4'h7: begin
            sp = (sp + 7) % 8;
            m_pc = m_stk[sp];
         end
         4'h8: m_pc = {m_lat, d[7:0]};
         4'h9: m_lat = d[4:0];
         4'hA: m_ptr = d[7:0];
         4'hB: m_bank = d[0];
         default: ;
      endcase
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      cmd <= 4'h0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 10);
      if (pready !== 1'b1) begin
         fails++;
         close_out();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (w && a == 12'h000) m_pc = {m_lat, d[7:0]};
      if (w && a == 12'h004) m_lat = d[4:0];
      if (w && a == 12'h008) m_ptr = d[7:0];
      if (w && a == 12'h00C) m_bank = d[0];
      @(posedge ref_clk);
   endtask
   task automatic acc(input logic w, input logic [8:0] a);
      logic [8:0]  ea;
      logic        self;
      logic [11:0] e;
      logic [11:0] g;
      ea = (a[6:0] == 7'h00) ? {m_bank, m_ptr} : a;
      self = (a[6:0] == 7'h00) && (ea[6:0] == 7'h00);
      e = {1'b1, ea, w & !self, !w & self};
      cmd <= 4'h0;
      acc_valid <= 1'b1;
      acc_write <= w;
      acc_addr <= a;
      @(posedge ref_clk);
      acc_valid <= 1'b0;
      @(negedge ref_clk);
      g = {mem_valid, mem_addr, mem_write, mem_read_zero};
      chk_val({20'h0_0000, g}, {20'h0_0000, e});
      @(posedge ref_clk);
   endtask
   task automatic do_reset(input int n);
      rst <= 1'b1;
      repeat (n) @(posedge ref_clk);
      rst <= 1'b0;
      {m_pc, m_lat, m_ptr, m_bank, sp} = '0;
      @(posedge ref_clk);
   endtask
   initial begin
      do_reset(20);
      chk_pc(pc, 13'h0000);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 12'(i * 4), 32'h0000_0000);
         chk_val(rd, 32'h0000_0000);
      end
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk_val({rd[30:0], err}, 32'h0000_0001);
      apb(1'b1, 12'h004, 32'hFFFF_FFFA);
      apb(1'b1, 12'h000, 32'h0000_0034);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk_val(rd, 32'h0000_0034);
      op(4'h8, 13'h00FF);
      op(4'h8, 13'h0001);
      for (int i = 0; i < 10; i++) op(4'h3, 13'(rnd()));
      for (int i = 0; i < 10; i++) op(4'h5 + 4'(i % 3), 13'h0000);
      op(4'h4, 13'(rnd()));
      op(4'h7, 13'h0000);
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk_val(rd, 32'h0000_001A);
      for (int i = 0; i < 300; i++) begin
         op(4'h1 + 4'(rnd() % 11), 13'(rnd()));
      end
      op(4'hA, 13'h0013);
      apb(1'b1, 12'h008, 32'hFFFF_FF25);
      apb(1'b1, 12'h00C, 32'h0000_0001);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk_val(rd, 32'h0000_0025);
      acc(1'b0, 9'h000);
      acc(1'b1, 9'h080);
      op(4'hA, 13'h0080);
      acc(1'b0, 9'h000);
      acc(1'b1, 9'h100);
      for (int i = 0; i < 30; i++) begin
         r = 13'(rnd());
         acc(r[9], r[8:0]);
      end
      do_reset(2);
      chk_pc(pc, 13'h0000);
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk_val(rd, 32'h0000_0000);
      close_out();
   end
endmodule // program_counter_stack_indirect_tb_top
